// File: common/sync_action_pkg.sv
package sync_action_pkg;
  // address width, block and word index codes of the register window
  localparam int ADDR_W = 7;
  localparam logic [2:0] BLK_CTRL = 3'h0;
  localparam logic [2:0] BLK_PRESET = 3'h1;
  localparam logic [2:0] BLK_CAPTURE = 3'h2;
  localparam logic [2:0] BLK_UPPER = 3'h3;
  localparam logic [2:0] BLK_LOWER = 3'h4;
  localparam logic [1:0] IDX_CONFIG = 2'h0;
  localparam logic [1:0] IDX_STATUS = 2'h1;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  // configuration word field positions
  localparam int CFG_MASK_LSB = 0;
  localparam int CFG_MON_LSB = 8;
  localparam int CFG_TGT_LSB = 10;
  localparam int CFG_DRV_LSB = 13;
  localparam int CFG_CAP_LSB = 16;
  localparam int CFG_LOAD_LSB = 18;
  localparam int CFG_SRC_LSB = 21;
  // status word field positions
  localparam int STS_BUSY_LSB = 0;
  localparam int STS_AUX_LSB = 4;
  localparam int STS_HIT_LSB = 8;
  // activation factor codes
  localparam logic [7:0] EV_GE_UPPER = 8'h01;
  localparam logic [7:0] EV_LT_UPPER = 8'h02;
  localparam logic [7:0] EV_LT_LOWER = 8'h04;
  localparam logic [7:0] EV_GE_LOWER = 8'h08;
  localparam logic [7:0] EV_DRIVE_START = 8'h10;
  localparam logic [7:0] EV_DRIVE_END = 8'h20;
  localparam logic [7:0] EV_AUX_RISE = 8'h40;
  localparam logic [7:0] EV_AUX_FALL = 8'h80;
  localparam logic [7:0] EV_NONE = 8'h00;
  // drive action codes
  localparam logic [2:0] DRV_NONE = 3'h0;
  localparam logic [2:0] FIXED_PULSE_PLUS = 3'h1;
  localparam logic [2:0] FIXED_PULSE_MINUS = 3'h2;
  localparam logic [2:0] CONTINUOUS_PULSE_PLUS = 3'h3;
  localparam logic [2:0] CONTINUOUS_PULSE_MINUS = 3'h4;
  localparam logic [2:0] DECELERATING_STOP = 3'h5;
  localparam logic [2:0] IMMEDIATE_STOP = 3'h6;
  // capture action codes
  localparam logic [1:0] CAPTURE_NONE = 2'h0;
  localparam logic [1:0] CAPTURE_LOGICAL_POSITION = 2'h1;
  localparam logic [1:0] CAPTURE_REAL_POSITION = 2'h2;
  // load action codes
  localparam logic [2:0] LOAD_NONE = 3'h0;
  localparam logic [2:0] LOAD_LOGICAL_POSITION = 3'h1;
  localparam logic [2:0] LOAD_REAL_POSITION = 3'h2;
  localparam logic [2:0] LOAD_DRIVE_OFFSET = 3'h3;
  localparam logic [2:0] LOAD_DRIVE_SPEED = 3'h4;
endpackage

// File: core/avs_word_slave.sv
module avs_word_slave (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] rd_value,
  output logic waitrequest,
  output logic [31:0] readdata,
  output logic wr_fire
);
  typedef enum logic {SLV_IDLE, SLV_DONE} slv_phase_t;
  typedef struct packed {
    slv_phase_t phase;
    logic [31:0] rdata;
  } slv_state_t;
  slv_state_t st_reg;
  slv_state_t st_next;

  // one wait cycle, then the answer edge
  always_comb
  begin
    st_next = st_reg;
    case (st_reg.phase)
      SLV_IDLE:
      begin
        if (read || write)
        begin
          st_next.phase = SLV_DONE;
          st_next.rdata = read ? rd_value : 32'h0000_0000;
        end
      end
      SLV_DONE:
      begin
        st_next.phase = SLV_IDLE;
      end
      default:
      begin
        st_next.phase = SLV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // handshake outputs
  assign waitrequest = (read || write) && (st_reg.phase == SLV_IDLE);
  assign wr_fire = write && (st_reg.phase == SLV_DONE);
  assign readdata = st_reg.rdata;
endmodule

// File: core/sync_event_detect.sv
module sync_event_detect (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rearm,
  input wire logic [31:0] position,
  input wire logic [31:0] upper,
  input wire logic [31:0] lower,
  input wire logic busy,
  input wire logic aux,
  output logic [7:0] events
);
  typedef struct packed {
    logic armed;
    logic ge_up;
    logic ge_lo;
    logic busy;
    logic aux;
  } det_state_t;
  det_state_t st_reg;
  det_state_t st_next;
  logic ge_up;
  logic ge_lo;

  // signed compare against both compare values
  assign ge_up = $signed(position) >= $signed(upper);
  assign ge_lo = $signed(position) >= $signed(lower);

  // remember last levels; rearm skips one cycle of history
  always_comb
  begin
    st_next.armed = !rearm;
    st_next.ge_up = ge_up;
    st_next.ge_lo = ge_lo;
    st_next.busy = busy;
    st_next.aux = aux;
  end

  // transitions become activation events
  always_comb
  begin
    events = sync_action_pkg::EV_NONE;
    if (st_reg.armed)
    begin
      if (ge_up && !st_reg.ge_up)
        events = events | sync_action_pkg::EV_GE_UPPER;
      if (!ge_up && st_reg.ge_up)
        events = events | sync_action_pkg::EV_LT_UPPER;
      if (!ge_lo && st_reg.ge_lo)
        events = events | sync_action_pkg::EV_LT_LOWER;
      if (ge_lo && !st_reg.ge_lo)
        events = events | sync_action_pkg::EV_GE_LOWER;
      if (busy && !st_reg.busy)
        events = events | sync_action_pkg::EV_DRIVE_START;
      if (!busy && st_reg.busy)
        events = events | sync_action_pkg::EV_DRIVE_END;
      if (aux && !st_reg.aux)
        events = events | sync_action_pkg::EV_AUX_RISE;
      if (!aux && st_reg.aux)
        events = events | sync_action_pkg::EV_AUX_FALL;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
endmodule

// File: core/axis_synchronous_action_unit.sv
// Overview of operation
// - flag 0x01 on reaching upper compare, 0x02 below it, 0x04 below lower.
// - flag 0x08 when selected position reaches or passes the lower compare.
// - flag 0x10 when monitored axis starts driving, 0x20 when it ends.
// - flag 0x40 on a rising edge of the monitored axis third input.
// - flag 0x80 on a falling edge of the monitored axis third input.
// - activation mask is an OR of event codes; several may be enabled.
// - an all-zero mask disables every drive, capture and load action.
// - 3-bit target set picks next, second and third axis cyclically.
// - drive selector holds 0 to 7; zero and seven mean no drive action.
// - codes 1 and 2 start fixed-pulse drives plus or minus.
// - codes 3 and 4 start continuous drives plus or minus.
// - a start is ignored for any target axis already moving.
// - code 5 stops targets with deceleration, code 6 stops at once.
// - capture code 1 copies logical position; zero disables capture.
// - capture code 2 copies encoder position; only one code at a time.
// - captured value stays until the next capture event.
// - load code 1 loads preset into logical position; zero disables.
// - load code 2 loads preset into encoder position.
// - load code 3 loads preset as fixed-pulse offset.
// - load code 4 loads preset as new drive speed.
module axis_synchronous_action_unit (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [sync_action_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [3:0][31:0] LOGICAL_POSITION_COUNTER,
  input wire logic [3:0][31:0] ENCODER_POSITION_COUNTER,
  input wire logic [3:0] DRIVE_BUSY,
  input wire logic [3:0] AUX_INPUT_THREE,
  output logic [3:0] DRIVE_START,
  output logic DRIVE_MINUS,
  output logic DRIVE_FIXED,
  output logic [3:0] STOP_DECEL,
  output logic [3:0] STOP_NOW,
  output logic [3:0] LOAD_LOGICAL,
  output logic [3:0] LOAD_ENCODER,
  output logic [3:0] LOAD_OFFSET,
  output logic [3:0] LOAD_SPEED,
  output logic [3:0][31:0] PRESET_VALUE,
  output logic SYNC_EVENT
);
  typedef struct packed {
    logic [31:0] config_word;
    logic [3:0][31:0] preset;
    logic [3:0][31:0] capture;
    logic [3:0][31:0] upper;
    logic [3:0][31:0] lower;
    logic [3:0] aux_meta;
    logic [3:0] aux_sync;
    logic [7:0] last_hit;
    logic [3:0] start;
    logic minus;
    logic fixed;
    logic [3:0] stop_decel;
    logic [3:0] stop_now;
    logic [3:0] load_lp;
    logic [3:0] load_ep;
    logic [3:0] load_ofs;
    logic [3:0] load_spd;
    logic event_pulse;
  } unit_state_t;
  unit_state_t st_reg;
  unit_state_t st_next;

  logic wr_fire;
  logic [31:0] rd_value;
  logic [7:0] events;
  logic [7:0] mask;
  logic [1:0] mon;
  logic [2:0] tset;
  logic [2:0] drv;
  logic [1:0] cap;
  logic [2:0] load;
  logic [3:0] src_ep;
  logic [31:0] pos_sel;
  logic [3:0] tgt_axes;
  logic [3:0] affected;
  logic [3:0] start_ok;
  logic trig;
  logic [2:0] blk;
  logic [1:0] idx;

  // cyclic target decode relative to the monitored axis
  function automatic logic [3:0] target_axes(input logic [1:0] m,
                                             input logic [2:0] s);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 0; k < 3; k++)
      r[2'(m + 2'(k + 1))] = s[k];
    return r;
  endfunction

  function automatic logic [3:0] one_axis(input logic [1:0] m);
    logic [3:0] r;
    r = 4'h0;
    r[m] = 1'b1;
    return r;
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[b*8 +: 8] = new_v[b*8 +: 8];
    return r;
  endfunction

  // configuration fields
  assign mask = st_reg.config_word[sync_action_pkg::CFG_MASK_LSB +: 8];
  assign mon = st_reg.config_word[sync_action_pkg::CFG_MON_LSB +: 2];
  assign tset = st_reg.config_word[sync_action_pkg::CFG_TGT_LSB +: 3];
  assign drv = st_reg.config_word[sync_action_pkg::CFG_DRV_LSB +: 3];
  assign cap = st_reg.config_word[sync_action_pkg::CFG_CAP_LSB +: 2];
  assign load = st_reg.config_word[sync_action_pkg::CFG_LOAD_LSB +: 3];
  assign src_ep = st_reg.config_word[sync_action_pkg::CFG_SRC_LSB +: 4];
  assign blk = AVS_ADDRESS[6:4];
  assign idx = AVS_ADDRESS[3:2];

  // compare source of the monitored axis, target sets
  assign pos_sel = src_ep[mon] ? ENCODER_POSITION_COUNTER[mon]
                               : LOGICAL_POSITION_COUNTER[mon];
  assign tgt_axes = target_axes(mon, tset);
  assign affected = (tgt_axes != 4'h0) ? tgt_axes : one_axis(mon);
  assign start_ok = tgt_axes & ~DRIVE_BUSY;
  assign trig = |(events & mask);

  avs_word_slave slave (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .read(AVS_READ),
    .write(AVS_WRITE),
    .rd_value(rd_value),
    .waitrequest(AVS_WAITREQUEST),
    .readdata(AVS_READDATA),
    .wr_fire(wr_fire)
  );

  sync_event_detect detect (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .rearm(wr_fire && blk == sync_action_pkg::BLK_CTRL),
    .position(pos_sel),
    .upper(st_reg.upper[mon]),
    .lower(st_reg.lower[mon]),
    .busy(DRIVE_BUSY[mon]),
    .aux(st_reg.aux_sync[mon]),
    .events(events)
  );

  // read mux; unmapped words read zero
  always_comb
  begin
    rd_value = 32'h0000_0000;
    case (blk)
      sync_action_pkg::BLK_CTRL:
      begin
        if (idx == sync_action_pkg::IDX_CONFIG)
          rd_value = st_reg.config_word;
        else if (idx == sync_action_pkg::IDX_STATUS)
        begin
          rd_value[sync_action_pkg::STS_BUSY_LSB +: 4] = DRIVE_BUSY;
          rd_value[sync_action_pkg::STS_AUX_LSB +: 4] = st_reg.aux_sync;
          rd_value[sync_action_pkg::STS_HIT_LSB +: 8] = st_reg.last_hit;
        end
      end
      sync_action_pkg::BLK_PRESET: rd_value = st_reg.preset[idx];
      sync_action_pkg::BLK_CAPTURE: rd_value = st_reg.capture[idx];
      sync_action_pkg::BLK_UPPER: rd_value = st_reg.upper[idx];
      sync_action_pkg::BLK_LOWER: rd_value = st_reg.lower[idx];
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // register writes, pin sync and actions on each trigger
  always_comb
  begin
    st_next = st_reg;
    st_next.aux_meta = AUX_INPUT_THREE;
    st_next.aux_sync = st_reg.aux_meta;
    st_next.start = 4'h0;
    st_next.stop_decel = 4'h0;
    st_next.stop_now = 4'h0;
    st_next.load_lp = 4'h0;
    st_next.load_ep = 4'h0;
    st_next.load_ofs = 4'h0;
    st_next.load_spd = 4'h0;
    st_next.event_pulse = trig;
    if (wr_fire)
    begin
      case (blk)
        sync_action_pkg::BLK_CTRL:
          if (idx == sync_action_pkg::IDX_CONFIG)
            st_next.config_word = merge(st_reg.config_word, AVS_WRITEDATA,
                                        AVS_BYTEENABLE);
        sync_action_pkg::BLK_PRESET:
          st_next.preset[idx] = merge(st_reg.preset[idx], AVS_WRITEDATA,
                                      AVS_BYTEENABLE);
        sync_action_pkg::BLK_UPPER:
          st_next.upper[idx] = merge(st_reg.upper[idx], AVS_WRITEDATA,
                                     AVS_BYTEENABLE);
        sync_action_pkg::BLK_LOWER:
          st_next.lower[idx] = merge(st_reg.lower[idx], AVS_WRITEDATA,
                                     AVS_BYTEENABLE);
        default: st_next.config_word = st_reg.config_word;
      endcase
    end
    if (trig)
    begin
      st_next.last_hit = events & mask;
      // drive action, starts ignored for busy targets
      case (drv)
        sync_action_pkg::FIXED_PULSE_PLUS,
        sync_action_pkg::FIXED_PULSE_MINUS:
        begin
          st_next.start = start_ok;
          st_next.fixed = 1'b1;
          st_next.minus = (drv == sync_action_pkg::FIXED_PULSE_MINUS);
        end
        sync_action_pkg::CONTINUOUS_PULSE_PLUS,
        sync_action_pkg::CONTINUOUS_PULSE_MINUS:
        begin
          st_next.start = start_ok;
          st_next.fixed = 1'b0;
          st_next.minus = (drv == sync_action_pkg::CONTINUOUS_PULSE_MINUS);
        end
        sync_action_pkg::DECELERATING_STOP: st_next.stop_decel = tgt_axes;
        sync_action_pkg::IMMEDIATE_STOP: st_next.stop_now = tgt_axes;
        default: st_next.start = 4'h0;
      endcase
      // capture into the monitored axis buffer
      case (cap)
        sync_action_pkg::CAPTURE_LOGICAL_POSITION:
          st_next.capture[mon] = LOGICAL_POSITION_COUNTER[mon];
        sync_action_pkg::CAPTURE_REAL_POSITION:
          st_next.capture[mon] = ENCODER_POSITION_COUNTER[mon];
        default: st_next.capture = st_reg.capture;
      endcase
      // preset loads
      case (load)
        sync_action_pkg::LOAD_LOGICAL_POSITION:
          st_next.load_lp = one_axis(mon);
        sync_action_pkg::LOAD_REAL_POSITION:
          st_next.load_ep = one_axis(mon);
        sync_action_pkg::LOAD_DRIVE_OFFSET:
          st_next.load_ofs = affected;
        sync_action_pkg::LOAD_DRIVE_SPEED:
          st_next.load_spd = affected;
        default: st_next.load_lp = 4'h0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      st_reg <= '0;
      st_reg.config_word <= sync_action_pkg::CONFIG_RESET;
    end
    else
      st_reg <= st_next;
  end

  // outputs straight from flops
  assign DRIVE_START = st_reg.start;
  assign DRIVE_MINUS = st_reg.minus;
  assign DRIVE_FIXED = st_reg.fixed;
  assign STOP_DECEL = st_reg.stop_decel;
  assign STOP_NOW = st_reg.stop_now;
  assign LOAD_LOGICAL = st_reg.load_lp;
  assign LOAD_ENCODER = st_reg.load_ep;
  assign LOAD_OFFSET = st_reg.load_ofs;
  assign LOAD_SPEED = st_reg.load_spd;
  assign PRESET_VALUE = st_reg.preset;
  assign SYNC_EVENT = st_reg.event_pulse;

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  zero_mask_a: assert property ((mask == 8'h00) |=> !SYNC_EVENT)
    else $error("action with zero mask");
  busy_start_a: assert property (1'b1 |=>
      ((DRIVE_START & $past(DRIVE_BUSY)) == 4'h0))
    else $error("start issued to busy axis");
  cont_start_a: assert property ((trig && drv ==
      sync_action_pkg::CONTINUOUS_PULSE_MINUS) |=>
      (DRIVE_START == $past(start_ok)) && DRIVE_MINUS && !DRIVE_FIXED)
    else $error("continuous minus start wrong");
  fixed_start_a: assert property ((trig && drv ==
      sync_action_pkg::FIXED_PULSE_PLUS) |=>
      (DRIVE_START == $past(start_ok)) && !DRIVE_MINUS && DRIVE_FIXED)
    else $error("fixed plus start wrong");
  stop_decel_a: assert property ((trig && drv ==
      sync_action_pkg::DECELERATING_STOP) |=>
      (STOP_DECEL == $past(tgt_axes)) && (STOP_NOW == 4'h0))
    else $error("decelerating stop wrong");
  capture_lp_a: assert property ((trig && !wr_fire && cap ==
      sync_action_pkg::CAPTURE_LOGICAL_POSITION) |=>
      st_reg.capture[mon] == $past(LOGICAL_POSITION_COUNTER[mon]))
    else $error("logical capture missing");
  capture_hold_a: assert property (!trig |=> $stable(st_reg.capture))
    else $error("capture changed without event");
  load_speed_a: assert property ((trig && load ==
      sync_action_pkg::LOAD_DRIVE_SPEED) |=> LOAD_SPEED == $past(affected))
    else $error("speed load targets wrong");
  aux_rise_a: assert property ((events[6]) |->
      st_reg.aux_sync[mon] && !$past(st_reg.aux_sync[mon]))
    else $error("aux rise without edge");
  upper_cross_a: assert property ((events[0]) |->
      ($signed(pos_sel) >= $signed(st_reg.upper[mon])) &&
      !$past($signed(pos_sel) >= $signed(st_reg.upper[mon])))
    else $error("upper event without crossing");
  bus_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
      |=> !AVS_WAITREQUEST)
    else $error("bus answer late");
endmodule

// File: sim/drive_partner.sv
module drive_partner (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] start,
  input wire logic fixed,
  input wire logic [3:0] decel,
  input wire logic [3:0] halt,
  input wire logic [3:0] ld_log,
  input wire logic [3:0] ld_enc,
  input wire logic [3:0][31:0] preset,
  input wire logic [3:0] kick,
  input wire logic set_en,
  input wire logic [31:0] set_val,
  output logic [3:0][31:0] lpos,
  output logic [3:0][31:0] epos,
  output logic [3:0] busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int left [4];
  // fixed moves run out a count, continuous ones run until stopped
  always @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (!rst_b || halt[i] || left[i] == 1)
        left[i] <= 0;
      else if (kick[i] || (start[i] && left[i] == 0))
        left[i] <= (fixed || kick[i]) ? 60 : -1;
      else if (decel[i] && left[i] != 0)
        left[i] <= 4;
      else if (left[i] > 1)
        left[i] <= left[i] - 1;
    end
  end
  // axis moving flags
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      busy[i] = (left[i] != 0);
  end
  // counters follow preset loads; encoder sits a fixed step ahead
  always @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (!rst_b)
      begin
        lpos[i] <= 32'h0;
        epos[i] <= 32'h0;
      end
      else
      begin
        if (set_en)
        begin
          lpos[i] <= set_val;
          epos[i] <= set_val + 32'h7;
        end
        if (ld_log[i])
          lpos[i] <= preset[i];
        if (ld_enc[i])
          epos[i] <= preset[i];
      end
    end
  end
endmodule

// File: sim/tb.sv
`define CHECK_EQ(got, exp, msg) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("[FAIL] %0t %s", $time, msg); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [sync_action_pkg::ADDR_W-1:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] aux = 4'h0;
  logic [3:0] kick = 4'h0;
  logic set_en = 1'b0;
  logic [31:0] set_val = 32'h0;
  logic [31:0] rdata, q, lx, ex;
  logic wait_r, minus, fixed, sev;
  logic [3:0] busy, start, decel, halt, ldl, lde, ldo, lds, tm, st;
  logic [3:0][31:0] lpos, epos, preset;
  logic [31:0] pv [4];
  logic [31:0] cp [4] = '{32'h5DC, 32'h1F4, 32'hFFFFFA24, 32'hFFFFFE0C};
  logic [7:0] ce [4] = '{8'h01, 8'h02, 8'h04, 8'h08};
  int codes [9] = '{1, 3, 6, 2, 5, 4, 6, 0, 7};
  logic [2:0] ts, d;
  int mon;
  int errors = 0;
  int checks_done = 0;
  axis_synchronous_action_unit u_axis_synchronous_action_unit (
    .REF_CLK(clk),
    .RST_B(rst_b),
    .AVS_ADDRESS(addr),
    .AVS_READ(rd),
    .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_r),
    .LOGICAL_POSITION_COUNTER(lpos),
    .ENCODER_POSITION_COUNTER(epos),
    .DRIVE_BUSY(busy),
    .AUX_INPUT_THREE(aux),
    .DRIVE_START(start),
    .DRIVE_MINUS(minus),
    .DRIVE_FIXED(fixed),
    .STOP_DECEL(decel),
    .STOP_NOW(halt),
    .LOAD_LOGICAL(ldl),
    .LOAD_ENCODER(lde),
    .LOAD_OFFSET(ldo),
    .LOAD_SPEED(lds),
    .PRESET_VALUE(preset),
    .SYNC_EVENT(sev)
  );
  drive_partner u_drive_partner (
    .clk(clk),
    .rst_b(rst_b),
    .start(start),
    .fixed(fixed),
    .decel(decel),
    .halt(halt),
    .ld_log(ldl),
    .ld_enc(lde),
    .preset(preset),
    .kick(kick),
    .set_en(set_en),
    .set_val(set_val),
    .lpos(lpos),
    .epos(epos),
    .busy(busy)
  );
  // 50 MHz clock
  always #10 clk = ~clk;
  task automatic tally_and_finish();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one bus cycle, held until a rising edge sees waitrequest low
  task automatic bus(input logic w, input logic [6:0] a,
    input logic [31:0] dv);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= dv;
    @(posedge clk);
    while (wait_r !== 1'b0)
      @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic pin(input int i, input logic v);
    @(posedge clk);
    aux[i] <= v;
  endtask
  task automatic setp(input logic [31:0] v);
    @(posedge clk);
    set_en <= 1'b1;
    set_val <= v;
    @(posedge clk);
    set_en <= 1'b0;
  endtask
  task automatic wait_ev(input int lim);
    int n;
    n = 0;
    @(negedge clk);
    while (sev !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    `CHECK_EQ(sev, 1'b1, "sync event missing")
  endtask
  task automatic quiet(input int c);
    repeat (c)
    begin
      @(negedge clk);
      `CHECK_EQ({sev, start, halt, ldl}, 13'h0, "stray action")
    end
  endtask
  function automatic logic [31:0] cfg(logic [7:0] m, int mo,
    logic [2:0] t, logic [2:0] dv, logic [1:0] c, logic [2:0] ld);
    return {11'h0, ld, c, dv, t, mo[1:0], m};
  endfunction
  function automatic logic [3:0] tmask(int mo, logic [2:0] t);
    logic [3:0] m;
    m = 4'h0;
    for (int k = 0; k < 3; k++)
      if (t[k])
        m[(mo + k + 1) % 4] = 1'b1;
    return m;
  endfunction
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  // main sequence
  initial
  begin
    void'($urandom(32'h5E15));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    bus(0, 7'h00, 32'h0);
    `CHECK_EQ(q, sync_action_pkg::CONFIG_RESET, "config reset")
    bus(0, 7'h7C, 32'h0);
    `CHECK_EQ(q, 32'h0, "unmapped read")
    bus(1, 7'h20, 32'hFFFFFFFF);
    bus(0, 7'h20, 32'h0);
    `CHECK_EQ(q, 32'h0, "capture writable")
    for (int i = 0; i < 4; i++)
    begin
      pv[i] = $urandom;
      bus(1, 7'(16 + 4 * i), pv[i]);
      bus(0, 7'(16 + 4 * i), 32'h0);
      `CHECK_EQ(q, pv[i], "preset readback")
      `CHECK_EQ(preset[i], pv[i], "preset port")
    end
    // load and capture codes on axis U, aux rising edge
    lx = $urandom;
    ex = lx + 32'h7;
    setp(lx);
    for (int j = 1; j < 5; j++)
    begin
      pin(3, 1'b0);
      repeat (4) @(posedge clk);
      bus(1, 7'h00, cfg(8'h40, 3, 3'h0, 3'h0, 2'(j % 2 + 1), 3'(j)));
      pin(3, 1'b1);
      wait_ev(30);
      `CHECK_EQ({lds, ldo, lde, ldl}, 16'h8 << (4 * (j - 1)), "load")
      bus(0, 7'h2C, 32'h0);
      `CHECK_EQ(q, (j % 2) ? ex : lx, "capture value")
      if (j == 1)
        lx = pv[3];
      if (j == 2)
        ex = pv[3];
    end
    setp($urandom);
    bus(0, 7'h2C, 32'h0);
    `CHECK_EQ(q, lx, "capture not held")
    // every drive code against a random target set
    mon = $urandom_range(3, 0);
    ts = 3'($urandom_range(7, 1));
    tm = tmask(mon, ts);
    for (int i = 0; i < 9; i++)
    begin
      d = 3'(codes[i]);
      pin(mon, 1'b0);
      repeat (4) @(posedge clk);
      bus(1, 7'h00, cfg(8'h40, mon, ts, d, 2'h0,
        (d == 1 || d == 2) ? 3'h3 : 3'h0));
      pin(mon, 1'b1);
      wait_ev(30);
      st = (d > 0 && d < 5 && i != 1) ? tm : 4'h0;
      `CHECK_EQ(start, st, "drive start")
      `CHECK_EQ(ldo, (d == 1 || d == 2) ? tm : 4'h0, "offset")
      `CHECK_EQ(halt, (d == 6) ? tm : 4'h0, "stop now")
      `CHECK_EQ(decel, (d == 5) ? tm : 4'h0, "stop decel")
      if (st != 4'h0)
        `CHECK_EQ({minus, fixed}, {d == 2 || d == 4, d < 3}, "mode")
      repeat (10) @(posedge clk);
    end
    // compare crossings on axis Z, signed limits
    bus(1, 7'h38, 32'h3E8);
    bus(1, 7'h48, 32'hFFFFFC18);
    setp(32'h0);
    bus(1, 7'h00, cfg(8'h0F, 2, 3'h0, 3'h0, 2'h1, 3'h0));
    for (int k = 0; k < 4; k++)
    begin
      setp(cp[k]);
      wait_ev(30);
      bus(0, 7'h04, 32'h0);
      `CHECK_EQ(q[15:8], ce[k], "compare event")
      bus(0, 7'h28, 32'h0);
      `CHECK_EQ(q, cp[k], "compare capture")
    end
    // encoder as compare source: only the encoder reaches upper
    bus(1, 7'h00, cfg(8'h01, 2, 3'h0, 3'h0, 2'h2, 3'h0) |
      (32'h1 << (sync_action_pkg::CFG_SRC_LSB + 2)));
    setp(32'h3E1);
    wait_ev(30);
    bus(0, 7'h28, 32'h0);
    `CHECK_EQ(q, 32'h3E8, "encoder compare capture")
    // drive start and end together in one mask
    bus(1, 7'h00, cfg(8'h30, 0, 3'h0, 3'h0, 2'h0, 3'h0));
    @(posedge clk);
    kick <= 4'h1;
    @(posedge clk);
    kick <= 4'h0;
    wait_ev(30);
    wait_ev(90);
    // falling edge only, rising must stay silent
    bus(1, 7'h00, cfg(8'h80, 1, 3'h1, 3'h5, 2'h0, 3'h0));
    pin(1, 1'b1);
    quiet(8);
    pin(1, 1'b0);
    wait_ev(30);
    `CHECK_EQ(decel, 4'h4, "fall decel")
    quiet(8);
    // empty mask does nothing
    bus(1, 7'h00, cfg(8'h00, 0, 3'h7, 3'h3, 2'h1, 3'h1));
    pin(0, 1'b0);
    pin(0, 1'b1);
    quiet(12);
    tally_and_finish();
  end
endmodule
